// ===== bfs_pkg.sv
// Shared timing constants and state types of the ballast fault supervisor
package bfs_pkg;

  // Clock rate
  localparam int unsigned CLK_MHZ = 100;

  // Nominal times
  localparam int unsigned T_PRERUN_MS = 625;
  localparam int unsigned T_LAMP_OV_US = 620;
  localparam int unsigned T_RECT_MS = 2500;
  localparam int unsigned T_IDLE_MS = 2500;
  localparam int unsigned T_OC_US = 620;
  localparam int unsigned T_UV_LONG_MS = 800;
  localparam int unsigned T_UV_MIN_MS = 500;
  localparam int unsigned T_DT_FILT_NS = 280;
  localparam int unsigned T_DT_MIN_NS = 1250;
  localparam int unsigned T_DT_MAX_NS = 2500;

  // Cycle counts: exact products of the nominal times and the clock rate, no rounding
  localparam int unsigned PRERUN_CYC = T_PRERUN_MS * 1000 * CLK_MHZ;
  localparam int unsigned LAMP_OV_CYC = T_LAMP_OV_US * CLK_MHZ;
  localparam int unsigned RECT_CYC = T_RECT_MS * 1000 * CLK_MHZ;
  localparam int unsigned IDLE_CYC = T_IDLE_MS * 1000 * CLK_MHZ;
  localparam int unsigned OC_CYC = T_OC_US * CLK_MHZ;
  localparam int unsigned UV_LONG_CYC = T_UV_LONG_MS * 1000 * CLK_MHZ;
  localparam int unsigned UV_MIN_CYC = T_UV_MIN_MS * 1000 * CLK_MHZ;

  // Dead-time widths and limits
  localparam int unsigned DT_W = 8;
  localparam int unsigned FILT_W = 5;
  localparam int unsigned LS_W = 16;
  localparam int unsigned EXT_W = 8;
  localparam logic [FILT_W-1:0] DT_FILT_C = FILT_W'((T_DT_FILT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [DT_W-1:0] DT_MIN_C = DT_W'((T_DT_MIN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [DT_W-1:0] DT_MAX_C = DT_W'((T_DT_MAX_NS * CLK_MHZ) / 1000);

  // Number of synchronised comparator pins
  localparam int unsigned N_PINS = 12;

  typedef enum logic [2:0] {ST_WAIT, ST_START, ST_PRERUN, ST_RUN, ST_LATCH, ST_UV} bfs_state_t;
  typedef enum logic [2:0] {HB_OFF, HB_HS_ON, HB_DT_MEAS, HB_LS_ON, HB_DT_WAIT} bfs_hb_t;
  typedef enum logic [1:0] {PF_WAIT, PF_ON, PF_EXT} bfs_pf_t;
  typedef enum logic [1:0] {CS_OV, CS_RECT, CS_IDLE, CS_OC} bfs_cause_t;

endpackage : bfs_pkg

// ===== bfs_qual_timer.sv
// Fault qualification counter: flags a condition held for LIMIT cycles
`timescale 1ns/100ps
module bfs_qual_timer #(
  parameter int unsigned LIMIT = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_cond,
  output logic o_hit
);
  localparam int unsigned W = $clog2(LIMIT + 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Elaboration check
  if (LIMIT < 1) begin : g_bad
    $error("LIMIT must be at least one");
  end

  // Count while held, clear when dropped, saturate at limit
  always_comb begin
    if (!i_cond) begin
      cnt_d = '0;
    end else if (cnt_q != LIMIT[W-1:0]) begin
      cnt_d = cnt_q + 1'b1;
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign o_hit = (cnt_q == LIMIT[W-1:0]);

  chk_qual_drop: assert property (@(posedge i_clk) disable iff (i_reset)
    !i_cond |=> !o_hit) else $error("qualified flag outlived its condition");

endmodule : bfs_qual_timer

// ===== bfs_supervisor.sv
// Fault supervision, dead time and PFC gate timing of the ballast controller
`timescale 1ns/100ps
module bfs_supervisor
  import bfs_pkg::*;
#(
  parameter int unsigned PRERUN_CYC_P = PRERUN_CYC,
  parameter int unsigned LAMP_OV_CYC_P = LAMP_OV_CYC,
  parameter int unsigned RECT_CYC_P = RECT_CYC,
  parameter int unsigned IDLE_CYC_P = IDLE_CYC,
  parameter int unsigned OC_CYC_P = OC_CYC,
  parameter int unsigned UV_LONG_CYC_P = UV_LONG_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic I_PFC_OC,
  input wire logic I_ZCD_VALID,
  input wire logic I_PFC_ON_REQ,
  input wire logic [EXT_W-1:0] I_ZCD_EXT,
  input wire logic I_LAMP_AC_HI,
  input wire logic I_LAMP_DC_HI,
  input wire logic I_LAMP_SENSE_OK,
  input wire logic I_LAMP_INSERT,
  input wire logic I_LOAD_OK,
  input wire logic I_LS_BELOW_P100,
  input wire logic I_LS_BELOW_M100,
  input wire logic I_LS_ABOVE_2V,
  input wire logic I_BUS_BELOW_75,
  input wire logic I_BUS_ABOVE_12P5,
  input wire logic I_START,
  input wire logic I_AT_RUN_FREQ,
  input wire logic I_HS_OFF_REQ,
  input wire logic I_LS_OFF_REQ,
  output logic O_PFC_GATE,
  output logic O_HS_GATE,
  output logic O_LS_GATE,
  output logic O_RUN_MODE,
  output logic O_LATCHED,
  output logic O_BUS_UV,
  output logic O_RESTART,
  output logic O_SKIP_PREHEAT,
  output logic O_FULL_RESTART,
  output logic O_LAMP_OV_FAULT,
  output logic O_RECT_FAULT,
  output logic O_IDLE_FAULT,
  output logic O_OC_FAULT,
  output logic [DT_W-1:0] O_DEAD_TIME
);
  localparam int unsigned PW = $clog2(PRERUN_CYC_P + 1);
  localparam int unsigned UW = $clog2(UV_LONG_CYC_P + 1);
  localparam logic [PW-1:0] PRERUN_LAST = PW'(PRERUN_CYC_P - 1);
  localparam logic [UW-1:0] UV_LONG = UW'(UV_LONG_CYC_P);

  // Elaboration check
  if (PRERUN_CYC_P < 1 || UV_LONG_CYC_P < 1) begin : g_bad
    $error("timing parameters must be at least one cycle");
  end

  // Two-stage synchroniser for comparator pins
  logic [N_PINS-1:0] sy1_q;
  logic [N_PINS-1:0] sy2_q;
  logic s_pfc_oc, s_zcd, s_ac_hi, s_dc_hi, s_lamp_ok, s_insert;
  logic s_load_ok, s_p100, s_m100, s_2v, s_bus_lo, s_bus_12p5;

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      sy1_q <= '0;
      sy2_q <= '0;
    end else begin
      sy1_q <= {I_PFC_OC, I_ZCD_VALID, I_LAMP_AC_HI, I_LAMP_DC_HI, I_LAMP_SENSE_OK,
                I_LAMP_INSERT, I_LOAD_OK, I_LS_BELOW_P100, I_LS_BELOW_M100,
                I_LS_ABOVE_2V, I_BUS_BELOW_75, I_BUS_ABOVE_12P5};
      sy2_q <= sy1_q;
    end
  end

  assign {s_pfc_oc, s_zcd, s_ac_hi, s_dc_hi, s_lamp_ok, s_insert,
          s_load_ok, s_p100, s_m100, s_2v, s_bus_lo, s_bus_12p5} = sy2_q;

  // Mode state
  bfs_state_t st_q, st_d;
  bfs_cause_t cause_q, cause_d;
  logic retry_q, retry_d;
  logic [PW-1:0] prerun_q, prerun_d;
  logic [UW-1:0] uv_q, uv_d;
  logic restart_d, skip_d, full_d;
  logic drv_en_d, run_now;
  logic ov_hit, rect_hit, idle_hit, oc_hit;

  // Half-bridge state
  bfs_hb_t hb_q, hb_d;
  logic [DT_W-1:0] dt_cnt_q, dt_cnt_d, dt_q, dt_d;
  logic [FILT_W-1:0] filt_q, filt_d;
  logic [LS_W-1:0] ls_cnt_q, ls_cnt_d, ls_len_q, ls_len_d;
  logic idle_acc_q, idle_acc_d, idle_cond_q, idle_cond_d;
  logic oc_acc_q, oc_acc_d, oc_cond_q, oc_cond_d;

  // PFC state
  bfs_pf_t pf_q, pf_d;
  logic [EXT_W-1:0] ext_q, ext_d;
  logic zcd_prev_q, zrise;

  assign run_now = (st_q == ST_RUN);
  assign drv_en_d = (st_d == ST_START) || (st_d == ST_PRERUN) || (st_d == ST_RUN);

  // Fault qualification timers, armed in run only
  bfs_qual_timer #(.LIMIT(LAMP_OV_CYC_P)) u_ov (
    .i_clk(I_CLK), .i_reset(I_RESET), .i_cond(run_now && s_ac_hi), .o_hit(ov_hit));
  bfs_qual_timer #(.LIMIT(RECT_CYC_P)) u_rect (
    .i_clk(I_CLK), .i_reset(I_RESET), .i_cond(run_now && s_dc_hi), .o_hit(rect_hit));
  bfs_qual_timer #(.LIMIT(IDLE_CYC_P)) u_idle (
    .i_clk(I_CLK), .i_reset(I_RESET), .i_cond(run_now && idle_cond_q), .o_hit(idle_hit));
  bfs_qual_timer #(.LIMIT(OC_CYC_P)) u_oc (
    .i_clk(I_CLK), .i_reset(I_RESET), .i_cond(run_now && oc_cond_q), .o_hit(oc_hit));

  // Mode sequencing, retry, latch and undervoltage timer
  always_comb begin
    st_d = st_q;
    cause_d = cause_q;
    retry_d = retry_q;
    prerun_d = prerun_q;
    uv_d = uv_q;
    restart_d = 1'b0;
    skip_d = 1'b0;
    full_d = 1'b0;
    case (st_q)
      ST_WAIT: begin
        if (I_START) begin
          st_d = ST_START;
        end
      end
      ST_START: begin
        if (I_AT_RUN_FREQ) begin
          st_d = ST_PRERUN;
          prerun_d = '0;
        end
      end
      ST_PRERUN: begin
        if (prerun_q == PRERUN_LAST) begin
          st_d = ST_RUN;
          uv_d = '0;
        end else begin
          prerun_d = prerun_q + 1'b1;
        end
      end
      ST_RUN: begin
        if (s_bus_lo) begin
          st_d = ST_UV;
        end else if (ov_hit || rect_hit || idle_hit || oc_hit) begin
          if (ov_hit) begin
            cause_d = CS_OV;
          end else if (rect_hit) begin
            cause_d = CS_RECT;
          end else if (idle_hit) begin
            cause_d = CS_IDLE;
          end else begin
            cause_d = CS_OC;
          end
          if (retry_q) begin
            st_d = ST_LATCH;
          end else begin
            retry_d = 1'b1;
            restart_d = 1'b1;
            st_d = ST_START;
          end
        end
      end
      ST_LATCH: begin
        if ((cause_q == CS_OV && !s_ac_hi && s_insert) ||
            (cause_q == CS_RECT && s_insert) ||
            ((cause_q == CS_IDLE || cause_q == CS_OC) && s_load_ok)) begin
          retry_d = 1'b0;
          restart_d = 1'b1;
          st_d = ST_START;
        end
      end
      ST_UV: begin
        if (s_bus_lo && uv_q != UV_LONG) begin
          uv_d = uv_q + 1'b1;
        end
        if (uv_q == UV_LONG) begin
          full_d = 1'b1;
          retry_d = 1'b0;
          st_d = ST_WAIT;
        end else if (s_lamp_ok && s_bus_12p5) begin
          skip_d = 1'b1;
          st_d = ST_START;
        end
      end
      default: begin
        st_d = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      st_q <= ST_WAIT;
      cause_q <= CS_OV;
      retry_q <= 1'b0;
      prerun_q <= '0;
      uv_q <= '0;
      O_RESTART <= 1'b0;
      O_SKIP_PREHEAT <= 1'b0;
      O_FULL_RESTART <= 1'b0;
      O_RUN_MODE <= 1'b0;
      O_LATCHED <= 1'b0;
      O_BUS_UV <= 1'b0;
      O_LAMP_OV_FAULT <= 1'b0;
      O_RECT_FAULT <= 1'b0;
      O_IDLE_FAULT <= 1'b0;
      O_OC_FAULT <= 1'b0;
    end else begin
      st_q <= st_d;
      cause_q <= cause_d;
      retry_q <= retry_d;
      prerun_q <= prerun_d;
      uv_q <= uv_d;
      O_RESTART <= restart_d;
      O_SKIP_PREHEAT <= skip_d;
      O_FULL_RESTART <= full_d;
      O_RUN_MODE <= (st_d == ST_RUN);
      O_LATCHED <= (st_d == ST_LATCH);
      O_BUS_UV <= (st_d == ST_UV);
      O_LAMP_OV_FAULT <= ov_hit;
      O_RECT_FAULT <= rect_hit;
      O_IDLE_FAULT <= idle_hit;
      O_OC_FAULT <= oc_hit;
    end
  end

  // Half-bridge sequencing with dead-time measurement and load checks
  always_comb begin
    hb_d = hb_q;
    dt_cnt_d = dt_cnt_q;
    filt_d = filt_q;
    dt_d = dt_q;
    ls_cnt_d = ls_cnt_q;
    ls_len_d = ls_len_q;
    idle_acc_d = idle_acc_q;
    idle_cond_d = idle_cond_q;
    oc_acc_d = oc_acc_q;
    oc_cond_d = oc_cond_q;
    case (hb_q)
      HB_OFF: begin
        hb_d = HB_DT_WAIT;
        dt_cnt_d = '0;
      end
      HB_HS_ON: begin
        if (s_2v) begin
          oc_acc_d = 1'b1;
        end
        if (I_HS_OFF_REQ) begin
          hb_d = HB_DT_MEAS;
          dt_cnt_d = '0;
          filt_d = '0;
          oc_cond_d = oc_acc_d;
          oc_acc_d = 1'b0;
        end
      end
      HB_DT_MEAS: begin
        dt_cnt_d = dt_cnt_q + 1'b1;
        if (!s_m100) begin
          filt_d = '0;
        end else if (filt_q != DT_FILT_C) begin
          filt_d = filt_q + 1'b1;
        end
        if ((filt_d == DT_FILT_C && dt_cnt_d >= DT_MIN_C) || dt_cnt_d == DT_MAX_C) begin
          dt_d = dt_cnt_d;
          hb_d = HB_LS_ON;
          ls_cnt_d = '0;
          idle_acc_d = 1'b1;
        end
      end
      HB_LS_ON: begin
        if (ls_cnt_q != {LS_W{1'b1}}) begin
          ls_cnt_d = ls_cnt_q + 1'b1;
        end
        if (ls_cnt_q >= (ls_len_q >> 1) && !s_p100) begin
          idle_acc_d = 1'b0;
        end
        if (I_LS_OFF_REQ) begin
          ls_len_d = ls_cnt_q;
          idle_cond_d = idle_acc_d;
          hb_d = HB_DT_WAIT;
          dt_cnt_d = '0;
        end
      end
      HB_DT_WAIT: begin
        dt_cnt_d = dt_cnt_q + 1'b1;
        if (dt_cnt_d == dt_q) begin
          hb_d = HB_HS_ON;
          if (s_m100) begin
            oc_acc_d = 1'b1;
          end
        end
      end
      default: begin
        hb_d = HB_OFF;
      end
    endcase
    if (!drv_en_d) begin
      hb_d = HB_OFF;
      idle_acc_d = 1'b0;
      idle_cond_d = 1'b0;
      oc_acc_d = 1'b0;
      oc_cond_d = 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      hb_q <= HB_OFF;
      dt_cnt_q <= '0;
      filt_q <= '0;
      dt_q <= DT_MAX_C;
      ls_cnt_q <= '0;
      ls_len_q <= '0;
      idle_acc_q <= 1'b0;
      idle_cond_q <= 1'b0;
      oc_acc_q <= 1'b0;
      oc_cond_q <= 1'b0;
      O_HS_GATE <= 1'b0;
      O_LS_GATE <= 1'b0;
    end else begin
      hb_q <= hb_d;
      dt_cnt_q <= dt_cnt_d;
      filt_q <= filt_d;
      dt_q <= dt_d;
      ls_cnt_q <= ls_cnt_d;
      ls_len_q <= ls_len_d;
      idle_acc_q <= idle_acc_d;
      idle_cond_q <= idle_cond_d;
      oc_acc_q <= oc_acc_d;
      oc_cond_q <= oc_cond_d;
      O_HS_GATE <= (hb_d == HB_HS_ON);
      O_LS_GATE <= (hb_d == HB_LS_ON);
    end
  end

  assign O_DEAD_TIME = dt_q;

  // PFC gate: loop on-time, stretch, current limit cut
  assign zrise = s_zcd && !zcd_prev_q;

  always_comb begin
    pf_d = pf_q;
    ext_d = ext_q;
    case (pf_q)
      PF_WAIT: begin
        if (zrise && I_PFC_ON_REQ && !s_pfc_oc) begin
          pf_d = PF_ON;
        end
      end
      PF_ON: begin
        if (s_pfc_oc) begin
          pf_d = PF_WAIT;
        end else if (!I_PFC_ON_REQ) begin
          pf_d = (I_ZCD_EXT == '0) ? PF_WAIT : PF_EXT;
          ext_d = '0;
        end
      end
      PF_EXT: begin
        ext_d = ext_q + 1'b1;
        if (s_pfc_oc || ext_d == I_ZCD_EXT) begin
          pf_d = PF_WAIT;
        end
      end
      default: begin
        pf_d = PF_WAIT;
      end
    endcase
    if (!drv_en_d) begin
      pf_d = PF_WAIT;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      pf_q <= PF_WAIT;
      ext_q <= '0;
      zcd_prev_q <= 1'b0;
      O_PFC_GATE <= 1'b0;
    end else begin
      pf_q <= pf_d;
      ext_q <= ext_d;
      zcd_prev_q <= s_zcd;
      O_PFC_GATE <= (pf_d == PF_ON) || (pf_d == PF_EXT);
    end
  end

  // Checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RESET);

  chk_pfc_oc_cut: assert property (s_pfc_oc |=> !O_PFC_GATE)
    else $error("PFC gate stayed on during current limit");
  chk_pfc_zcd_resume: assert property ($rose(O_PFC_GATE) |-> $past(zrise))
    else $error("PFC gate started without zero-current edge");
  chk_prerun_length: assert property (
    (st_q == ST_RUN && $past(st_q) == ST_PRERUN) |-> $past(prerun_q) == PRERUN_LAST)
    else $error("pre-run ended at wrong count");
  chk_eol_run_only: assert property ((st_q != ST_RUN) |=> !(ov_hit || rect_hit))
    else $error("end-of-life detection active outside run");
  chk_dead_time_range: assert property (
    (hb_q != HB_OFF) |-> (dt_q >= DT_MIN_C && dt_q <= DT_MAX_C))
    else $error("stored dead time out of range");
  chk_dead_time_store: assert property (
    (hb_q == HB_LS_ON && $past(hb_q) == HB_DT_MEAS) |-> dt_q == $past(dt_cnt_q) + 1'b1)
    else $error("dead time not stored at low-side turn-on");
  chk_hs_after_wait: assert property (
    (hb_q == HB_HS_ON && $past(hb_q) == HB_DT_WAIT) |-> $past(dt_cnt_q) + 1'b1 == dt_q)
    else $error("high side turned on before dead time");
  chk_uv_drivers_off: assert property (
    (st_q == ST_RUN && s_bus_lo) |=> !O_PFC_GATE && !O_HS_GATE && !O_LS_GATE)
    else $error("drivers still on after bus undervoltage");
  chk_uv_timer_clear: assert property (
    (st_q == ST_RUN && $past(st_q) != ST_RUN) |-> uv_q == '0)
    else $error("undervoltage timer not cleared in run");
  chk_latch_one_retry: assert property (
    (st_q == ST_LATCH && $past(st_q) == ST_RUN) |-> $past(retry_q))
    else $error("latched without prior restart");

  cov_run: cover property (st_q == ST_RUN);
  cov_latch: cover property (st_q == ST_LATCH);
  cov_skip: cover property (O_SKIP_PREHEAT);
  cov_hs_cycle: cover property (hb_q == HB_HS_ON && $past(hb_q) == HB_DT_WAIT);

endmodule : bfs_supervisor

// ===== bfs_load_model.sv
// Lamp load and half-bridge midpoint as seen by the low-side comparators
`timescale 1ns/100ps
module bfs_load_model (
  input wire logic i_clk,
  input wire logic i_hs_gate,
  input wire logic i_ls_gate,
  input wire logic [8:0] i_swing_dly,
  input wire logic i_idle,
  output logic o_below_m100,
  output logic o_below_p100
);
  int unsigned off_cnt = 0;
  logic after_hs = 1'b0;

  // Midpoint swings i_swing_dly cycles after the high side opens
  always @(posedge i_clk) begin
    off_cnt <= (i_hs_gate || i_ls_gate) ? 0 : off_cnt + 1;
    after_hs <= i_hs_gate ? 1'b1 : (i_ls_gate ? 1'b0 : after_hs);
  end

  // Negative sense only in the dead time after high-side off; 1FF never swings
  assign o_below_m100 = !i_hs_gate && !i_ls_gate && after_hs && i_swing_dly != 9'h1FF &&
                        off_cnt >= i_swing_dly;
  // A missing load leaves the sense low through the whole low-side on-time
  assign o_below_p100 = i_idle || !i_ls_gate;
endmodule : bfs_load_model

// ===== test_ballast_fault_supervisor.sv
// Self-checking bench of the ballast fault supervisor
`timescale 1ns/100ps
module test_ballast_fault_supervisor;
  import bfs_pkg::*;
  localparam int unsigned PRE = 20;
  localparam int unsigned UVL = 30;
  logic I_CLK = 1'b0;
  logic I_RESET = 1'b1;
  logic pfc_oc = 1'b0, zcd = 1'b0, on_req = 1'b0, ac_hi = 1'b0, dc_hi = 1'b0;
  logic sense_ok = 1'b0, insert = 1'b0, load_ok = 1'b0, above_2v = 1'b0, bus_lo = 1'b0;
  logic bus_ok = 1'b1, start = 1'b0, at_freq = 1'b0, hs_off = 1'b0, ls_off = 1'b0;
  logic idle = 1'b0, after_ls = 1'b0;
  logic [1:0] run_h = 2'b00;
  logic [EXT_W-1:0] zcd_ext = 8'h00;
  logic [8:0] swing = 9'h014;
  logic below_m100, below_p100, pfc_g, hs_g, ls_g, run, latched, bus_uv, restart, skip, full;
  logic f_ov, f_rect, f_idle, f_oc;
  logic [DT_W-1:0] dead;
  logic [10:0] flags;
  logic [31:0] seed = 32'h4843126e;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, hs_len = 0, ls_len = 0, gap = 0;
  int n_restart = 0, n0, t, n;
  int q_gap[$];

  assign flags = {f_oc, f_idle, f_rect, f_ov, pfc_g, full, skip, restart, bus_uv, latched, run};

  bfs_supervisor #(.PRERUN_CYC_P(PRE), .LAMP_OV_CYC_P(10), .RECT_CYC_P(20), .IDLE_CYC_P(20),
    .OC_CYC_P(10), .UV_LONG_CYC_P(UVL)) i_bfs_supervisor (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_PFC_OC(pfc_oc), .I_ZCD_VALID(zcd),
    .I_PFC_ON_REQ(on_req), .I_ZCD_EXT(zcd_ext), .I_LAMP_AC_HI(ac_hi), .I_LAMP_DC_HI(dc_hi),
    .I_LAMP_SENSE_OK(sense_ok), .I_LAMP_INSERT(insert), .I_LOAD_OK(load_ok),
    .I_LS_BELOW_P100(below_p100), .I_LS_BELOW_M100(below_m100), .I_LS_ABOVE_2V(above_2v),
    .I_BUS_BELOW_75(bus_lo), .I_BUS_ABOVE_12P5(bus_ok), .I_START(start),
    .I_AT_RUN_FREQ(at_freq), .I_HS_OFF_REQ(hs_off), .I_LS_OFF_REQ(ls_off),
    .O_PFC_GATE(pfc_g), .O_HS_GATE(hs_g), .O_LS_GATE(ls_g), .O_RUN_MODE(run),
    .O_LATCHED(latched), .O_BUS_UV(bus_uv), .O_RESTART(restart), .O_SKIP_PREHEAT(skip),
    .O_FULL_RESTART(full), .O_LAMP_OV_FAULT(f_ov), .O_RECT_FAULT(f_rect),
    .O_IDLE_FAULT(f_idle), .O_OC_FAULT(f_oc), .O_DEAD_TIME(dead));

  bfs_load_model i_bfs_load_model (.i_clk(I_CLK), .i_hs_gate(hs_g), .i_ls_gate(ls_g),
    .i_swing_dly(swing), .i_idle(idle), .o_below_m100(below_m100), .o_below_p100(below_p100));

  // Clock
  always #5 I_CLK = ~I_CLK;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  // Waits a bounded number of edges for one output flag
  task automatic wait_flag(input int b, input int lim, output int took);
    took = 0;
    while (flags[b] !== 1'b1 && took < lim) begin
      @(posedge I_CLK);
      #1;
      took++;
    end
  endtask : wait_flag

  task automatic go_run(input bit timed);
    int w;
    @(posedge I_CLK);
    start <= 1'b1;
    at_freq <= 1'b1;
    wait_flag(0, PRE + 40, w);
    check(32'(run), 1);
    if (timed) check(32'(w >= PRE && w <= PRE + 4), 1);
  endtask : go_run

  task automatic set_cond(input int c, input logic v);
    @(posedge I_CLK);
    case (c)
      0: ac_hi <= v;
      1: dc_hi <= v;
      2: idle <= v;
      default: above_2v <= v;
    endcase
  endtask : set_cond

  task automatic zcd_pulse();
    @(posedge I_CLK);
    zcd <= 1'b1;
    repeat (3) @(posedge I_CLK);
    zcd <= 1'b0;
  endtask : zcd_pulse

  // Short undervoltage of len cycles, recovered by lamp current and bus level
  task automatic uv_short(input int len);
    int w;
    @(posedge I_CLK);
    bus_lo <= 1'b1;
    wait_flag(2, 10, w);
    check(32'(w <= 4), 1);
    check(32'(hs_g | ls_g | pfc_g | run), 0);
    repeat (len) @(posedge I_CLK);
    bus_lo <= 1'b0;
    sense_ok <= 1'b1;
    wait_flag(4, 10, w);
    check(32'(skip), 1);
    check(32'(full), 0);
    @(posedge I_CLK);
    sense_ok <= 1'b0;
    go_run(0);
  endtask : uv_short

  // Half-bridge on-times, gap model, watchdog and per-cycle monitors
  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    hs_len <= hs_g ? hs_len + 1 : 0;
    ls_len <= ls_g ? ls_len + 1 : 0;
    hs_off <= hs_g && hs_len == 30;
    ls_off <= ls_g && ls_len == 30;
    gap <= (hs_g || ls_g) ? 0 : gap + 1;
    if (ls_g) begin
      after_ls <= 1'b1;
    end else if (hs_g && after_ls) begin
      q_gap.push_back(gap);
      after_ls <= 1'b0;
    end
    if (restart === 1'b1) n_restart <= n_restart + 1;
    if (!I_RESET) check(32'(hs_g & ls_g), 0);
    // Fault flags are registered, so they may trail the run flag by two cycles
    run_h <= {run_h[0], run};
    if (!I_RESET && run !== 1'b1 && run_h == 2'b00) check(32'(f_ov | f_rect), 0);
    if (cyc == 90000) begin
      n_mismatch++;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge I_CLK);
    I_RESET <= 1'b0;
    @(posedge I_CLK);
    #1;
    check(32'(dead), 32'h000000FA);
    check(32'(flags), 0);
    go_run(1);
    // Dead time: early swing clamps low, none forces high, mid is measured
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      @(posedge I_CLK);
      swing <= (k == 0) ? 9'h014 : (k == 1) ? 9'h1FF : 9'(150 + seed[5:0]);
      repeat (1500) @(posedge I_CLK);
      q_gap.delete();
      repeat (1200) @(posedge I_CLK);
      #1;
      if (k == 0) check(32'(dead), 125);
      if (k == 1) check(32'(dead), 250);
      if (k == 2) check(32'(dead >= swing + 28 && dead <= swing + 34), 1);
      foreach (q_gap[i]) check(q_gap[i], 32'(dead));
    end
    // PFC stretch by the zero-current setting, then current-limit cut
    for (int k = 0; k < 3; k++) begin
      seed = xs(seed);
      @(posedge I_CLK);
      zcd_ext <= 8'(seed[4:0] + 1);
      on_req <= 1'b1;
      zcd_pulse();
      wait_flag(6, 5, t);
      check(32'(pfc_g), 1);
      repeat (4) @(posedge I_CLK);
      on_req <= 1'b0;
      n = 0;
      forever begin
        @(posedge I_CLK);
        #1;
        if (pfc_g !== 1'b1 || n > 300) break;
        n++;
      end
      check(n, 32'(zcd_ext));
    end
    @(posedge I_CLK);
    on_req <= 1'b1;
    zcd_pulse();
    wait_flag(6, 5, t);
    @(posedge I_CLK);
    pfc_oc <= 1'b1;
    repeat (4) @(posedge I_CLK);
    #1;
    check(32'(pfc_g), 0);
    @(posedge I_CLK);
    pfc_oc <= 1'b0;
    repeat (8) @(posedge I_CLK);
    #1;
    check(32'(pfc_g), 0);
    zcd_pulse();
    wait_flag(6, 5, t);
    check(32'(pfc_g), 1);
    @(posedge I_CLK);
    on_req <= 1'b0;
    // Faults: one retry, latched power down, then release
    for (int c = 0; c < 4; c++) begin
      n0 = n_restart;
      set_cond(c, 1'b1);
      wait_flag(7 + c, 12000, t);
      check(32'(flags[7 + c]), 1);
      if (c == 0) check(32'(t >= 10 && t <= 14), 1);
      wait_flag(3, 4, t);
      check(32'(restart), 1);
      wait_flag(1, 12000, t);
      check(32'(latched), 1);
      check(n_restart, n0 + 1);
      repeat (2) @(posedge I_CLK);
      #1;
      check(32'(hs_g | ls_g | pfc_g), 0);
      if (c == 1) begin
        @(posedge I_CLK);
        load_ok <= 1'b1;
        repeat (20) @(posedge I_CLK);
        load_ok <= 1'b0;
        #1;
        check(32'(latched), 1);
      end
      set_cond(c, 1'b0);
      if (c < 2) insert <= 1'b1;
      else load_ok <= 1'b1;
      wait_flag(3, 20, t);
      check(32'(restart), 1);
      @(posedge I_CLK);
      insert <= 1'b0;
      load_ok <= 1'b0;
      go_run(0);
    end
    // Two short drops must not add up: timer clears on entering run
    uv_short(14);
    uv_short(14);
    // Long drop with the bus too low to allow the skip restart
    @(posedge I_CLK);
    bus_lo <= 1'b1;
    sense_ok <= 1'b1;
    bus_ok <= 1'b0;
    wait_flag(5, UVL + 20, t);
    check(32'(t >= UVL && t <= UVL + 6), 1);
    @(posedge I_CLK);
    bus_lo <= 1'b0;
    sense_ok <= 1'b0;
    bus_ok <= 1'b1;
    go_run(0);
    end_sim();
  end
endmodule : test_ballast_fault_supervisor
